// ---- verilog/bims_pkg.sv ----
// Constants, modes and timing figures for the boot and interface mode select
package bims_pkg;

    // Host-side command interface choices
    typedef enum logic [1:0] {
        BIMS_IF_UART,
        BIMS_IF_SPI,
        BIMS_IF_FIFO
    } bims_if_t;

    // Reset-time sequencing states
    typedef enum logic [1:0] {
        BIMS_ST_RESET,
        BIMS_ST_SETTLE,
        BIMS_ST_RUN
    } bims_state_t;

    // Clock figures in kHz
    localparam int unsigned BIMS_REF_KHZ = 12000;
    localparam int unsigned BIMS_SYS_KHZ = 100000;
    localparam int unsigned BIMS_CLK48_KHZ = 48000;
    localparam int unsigned BIMS_CLK24_KHZ = 24000;

    // Baud range limits
    localparam int unsigned BIMS_BAUD_MIN = 300;
    localparam int unsigned BIMS_BAUD_MAX = 1000000;
    localparam int unsigned BIMS_BAUD_BOOT = 115200;

    // Prescaler width and reset value (divisor of 48 MHz clock)
    localparam int BIMS_PRESC_W = 20;
    localparam logic [19:0] BIMS_PRESC_RST =
        20'(BIMS_CLK48_KHZ * 1000 / BIMS_BAUD_BOOT);
    localparam logic [19:0] BIMS_PRESC_MIN =
        20'(BIMS_CLK48_KHZ * 1000 / BIMS_BAUD_MAX);

    // Bootstrap ROM size in bytes and its address width
    localparam int BIMS_BOOT_ROM_BYTES = 512;
    localparam int BIMS_BOOT_AW = 9;
    localparam int BIMS_BOOT_SELECT_N_AW = 16;

    // Settle delay after reset release before pin functions turn on
    localparam int BIMS_SETTLE_CYC = 4;
    localparam logic [2:0] BIMS_SETTLE_LAST = 3'(BIMS_SETTLE_CYC - 1);

    // System timer period: 1 ms at the system clock
    localparam int unsigned BIMS_TICK_US = 1000;
    localparam int unsigned BIMS_TICK_CYC =
        BIMS_TICK_US * (BIMS_SYS_KHZ / 1000);

    // Fractional step for 48 MHz and 24 MHz enables off the system clock
    localparam logic [7:0] BIMS_STEP48 = 8'h7B;
    localparam logic [7:0] BIMS_STEP24 = 8'h3D;

endpackage : bims_pkg

// ---- verilog/bims_presc.sv ----
// UART prescaler: divides a clock enable down to the UART master tick
`timescale 1ns/100ps

module bims_presc
    import bims_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_tick_in,
    input wire logic [BIMS_PRESC_W-1:0] i_divisor,
    output logic o_tick
);

    ////////////////////////////////////////////////////////////////////////
    // Divider state
    logic [BIMS_PRESC_W-1:0] count_ff; // Counts input ticks
    logic [BIMS_PRESC_W-1:0] nxt_count;
    logic tick_ff; // Registered output pulse
    logic nxt_tick;
    logic [BIMS_PRESC_W-1:0] div_eff; // Divisor clamped to 1 Mbaud
    logic wrap; // Last input tick of a period

    // Clamp caps rate at 1 Mbaud, the top of the supported span
    assign div_eff = (i_divisor < BIMS_PRESC_MIN) ? BIMS_PRESC_MIN
                                                  : i_divisor; // R11
    assign wrap = i_tick_in && (count_ff >= div_eff - 1'b1);
    assign nxt_count = wrap ? '0
                     : (i_tick_in ? count_ff + 1'b1 : count_ff);
    assign nxt_tick = wrap; // R11

    ////////////////////////////////////////////////////////////////////////
    // Counter register
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            count_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;

endmodule // bims_presc

// ---- verilog/bims_mode_select.sv ----
// Reset-time interface and boot mode selection with clock enables
`timescale 1ns/100ps

// How it works
// [R1] Exactly one of UART, SPI, FIFO active; the code drives none of them until the latched mode is valid
// [R2] Straps decode: UU UART, UD SPI, DU FIFO, DD UART
// [R3] Straps sampled only during reset; latches sample them from reset release until run
// [R4] FIFO mode drives low strap as output
// [R5] Host holds boot select low, pulses reset
// [R6] Host holds boot select high, pulses reset
// [R7] Boot low at reset runs 512-byte ROM
// [R8] Blank part loads over UART only
// [R9] Host updater runs at least 115200 baud
// [R10] Make 24 and 48 MHz enables
// [R11] Adjustable prescaler spans 300 baud to 1 Mbaud
// [R12] System timer gives periodic interrupt
// [R13] Straps undriven until latched mode valid
module bims_mode_select
    import bims_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_boot_select_n,
    input wire logic i_mode_strap_low,
    input wire logic i_mode_strap_high,
    input wire logic i_flash_blank,
    input wire logic i_usb_upgrade_req,
    input wire logic i_strap_low_out,
    input wire logic [BIMS_PRESC_W-1:0] i_presc_divisor,
    input wire logic [BIMS_BOOT_SELECT_N_AW-1:0] i_fetch_addr,
    output logic o_mode_strap_low,
    output logic o_mode_strap_low_oe,
    output logic o_mode_strap_high,
    output logic o_mode_strap_high_oe,
    output logic o_if_uart,
    output logic o_if_spi,
    output logic o_if_fifo,
    output logic o_mode_valid,
    output logic o_boot_mode,
    output logic o_fetch_from_rom,
    output logic [BIMS_BOOT_AW-1:0] o_rom_addr,
    output logic o_uart_load_en,
    output logic o_usb_load_en,
    output logic o_clk48_en,
    output logic o_clk24_en,
    output logic o_uart_tick,
    output logic o_timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, second and third must agree
    logic [2:0] sync_lo_ff; // Low strap pipe
    logic [2:0] sync_hi_ff; // High strap pipe
    logic [2:0] sync_bt_ff; // Boot select pipe
    logic lo_ff; // Filtered low strap
    logic hi_ff; // Filtered high strap
    logic bt_ff; // Filtered boot select
    logic nxt_lo;
    logic nxt_hi;
    logic nxt_bt;

    // Accept a change only when stages two and three agree
    assign nxt_lo = (sync_lo_ff[1] == sync_lo_ff[2]) ? sync_lo_ff[2] : lo_ff;
    assign nxt_hi = (sync_hi_ff[1] == sync_hi_ff[2]) ? sync_hi_ff[2] : hi_ff;
    assign nxt_bt = (sync_bt_ff[1] == sync_bt_ff[2]) ? sync_bt_ff[2] : bt_ff;

    // Synchroniser pipes keep shifting through reset
    always_ff @(posedge i_clock)
    begin
        sync_lo_ff <= {sync_lo_ff[1:0], i_mode_strap_low};
        sync_hi_ff <= {sync_hi_ff[1:0], i_mode_strap_high};
        sync_bt_ff <= {sync_bt_ff[1:0], i_boot_select_n};
        lo_ff <= nxt_lo;
        hi_ff <= nxt_hi;
        bt_ff <= nxt_bt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap decode
    bims_if_t strap_mode; // Mode the straps ask for now

    // Both-down falls back to UART
    assign strap_mode = (hi_ff && !lo_ff) ? BIMS_IF_SPI
                      : (!hi_ff && lo_ff) ? BIMS_IF_FIFO
                      : BIMS_IF_UART; // R2

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and latches
    bims_state_t state_ff; // Reset sequencing state
    bims_state_t nxt_state;
    bims_if_t mode_ff; // Latched interface mode
    bims_if_t nxt_mode;
    logic boot_ff; // Latched bootloader flag
    logic nxt_boot;
    logic [2:0] settle_ff; // Settle counter after release
    logic [2:0] nxt_settle;

    // Latches track straps from reset release until run, freeze in run
    assign nxt_mode = (state_ff == BIMS_ST_RUN) ? mode_ff : strap_mode; // R3
    assign nxt_boot = (state_ff == BIMS_ST_RUN) ? boot_ff : !bt_ff; // R5 R6

    // Settle counter runs only while settling
    assign nxt_settle = (state_ff == BIMS_ST_SETTLE) ? settle_ff + 3'h1
                                                     : 3'h0;

    // Step from reset through settle into run
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            BIMS_ST_RESET:
                nxt_state = BIMS_ST_SETTLE;
            BIMS_ST_SETTLE:
                // Wait for pipes to carry released-reset strap levels
                if (settle_ff == BIMS_SETTLE_LAST)
                    nxt_state = BIMS_ST_RUN;
            default:
                nxt_state = BIMS_ST_RUN;
        endcase
    end

    // State and latch registers
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            state_ff <= BIMS_ST_RESET;
            mode_ff <= BIMS_IF_UART;
            boot_ff <= 1'b0;
            settle_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode; // R3
            boot_ff <= nxt_boot; // R7
            settle_ff <= nxt_settle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode outputs
    logic valid; // Latched mode is final

    assign valid = (state_ff == BIMS_ST_RUN);
    assign o_mode_valid = valid;
    // One-hot select, none before valid
    assign o_if_uart = valid && (mode_ff == BIMS_IF_UART); // R1
    assign o_if_spi = valid && (mode_ff == BIMS_IF_SPI); // R1
    assign o_if_fifo = valid && (mode_ff == BIMS_IF_FIFO); // R1
    assign o_boot_mode = valid && boot_ff;

    // Strap pins: low strap driven only in FIFO mode once valid
    assign o_mode_strap_low_oe = o_if_fifo; // R4 R13
    assign o_mode_strap_high_oe = 1'b0; // R13
    assign o_mode_strap_high = 1'b0;

    // Low strap output data from flip-flop
    logic strap_out_ff; // Registered pin data
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            strap_out_ff <= 1'b0;
        else
            strap_out_ff <= i_strap_low_out;
    end
    assign o_mode_strap_low = strap_out_ff;

    ////////////////////////////////////////////////////////////////////////
    // Program fetch steering and firmware load paths
    // Boot mode fetches from the bootstrap ROM window
    assign o_fetch_from_rom = o_boot_mode; // R7
    assign o_rom_addr = i_fetch_addr[BIMS_BOOT_AW-1:0]; // R7
    // Loading over UART only in boot mode with UART active
    assign o_uart_load_en = o_boot_mode && o_if_uart; // R8
    // USB upgrade only on a device that holds firmware
    assign o_usb_load_en = valid && !i_flash_blank
                           && i_usb_upgrade_req; // R8

    ////////////////////////////////////////////////////////////////////////
    // 48 MHz and 24 MHz enables by phase accumulation
    logic [7:0] acc48_ff; // 48 MHz phase
    logic [7:0] acc24_ff; // 24 MHz phase
    logic [8:0] sum48;
    logic [8:0] sum24;
    logic en48_ff; // 48 MHz enable pulse
    logic en24_ff; // 24 MHz enable pulse

    assign sum48 = {1'b0, acc48_ff} + {1'b0, BIMS_STEP48}; // R10
    assign sum24 = {1'b0, acc24_ff} + {1'b0, BIMS_STEP24}; // R10

    // Carry out marks one enable
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            acc48_ff <= 8'h00;
            acc24_ff <= 8'h00;
            en48_ff <= 1'b0;
            en24_ff <= 1'b0;
        end
        else
        begin
            acc48_ff <= sum48[7:0];
            acc24_ff <= sum24[7:0];
            en48_ff <= sum48[8];
            en24_ff <= sum24[8];
        end
    end
    assign o_clk48_en = en48_ff;
    assign o_clk24_en = en24_ff;

    ////////////////////////////////////////////////////////////////////////
    // UART prescaler off the 48 MHz enable
    bims_presc u_presc (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_tick_in(en48_ff),
        .i_divisor(i_presc_divisor),
        .o_tick(o_uart_tick)
    ); // R11

    ////////////////////////////////////////////////////////////////////////
    // System timer
    logic [16:0] tmr_ff; // Timer count
    logic [16:0] nxt_tmr;
    logic irq_ff; // Periodic pulse
    logic tmr_wrap;

    assign tmr_wrap = (tmr_ff == 17'(BIMS_TICK_CYC - 1));
    assign nxt_tmr = tmr_wrap ? 17'h00000 : tmr_ff + 17'h00001;

    // Free-running period counter
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            tmr_ff <= 17'h00000;
            irq_ff <= 1'b0;
        end
        else
        begin
            tmr_ff <= nxt_tmr;
            irq_ff <= tmr_wrap; // R12
        end
    end
    assign o_timer_irq = irq_ff;

endmodule // bims_mode_select

// ---- verif/bims_host_model.sv ----
// Host side: strap resistors, pin resolution and boot select driver
`timescale 1ns/100ps
module bims_host_model (
    input wire logic i_pull_low,
    input wire logic i_pull_high,
    input wire logic i_boot_run,
    input wire logic i_dev_low,
    input wire logic i_dev_low_oe,
    input wire logic i_dev_high,
    input wire logic i_dev_high_oe,
    output logic o_pin_low,
    output logic o_pin_high,
    output logic o_boot_select_n
);
    // Resistor sets the level unless the device drives the pin
    assign o_pin_low = i_dev_low_oe ? i_dev_low : i_pull_low;
    assign o_pin_high = i_dev_high_oe ? i_dev_high : i_pull_high;
    // Boot pin follows the bench level, which is set as reset asserts and held through the pulse
    assign o_boot_select_n = i_boot_run;
endmodule // bims_host_model

// ---- verif/bims_mode_select_sva.sv ----
// Port assertions for the mode select block
`timescale 1ns/100ps
module bims_mode_select_sva
    import bims_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_flash_blank,
    input wire logic [BIMS_BOOT_SELECT_N_AW-1:0] i_fetch_addr,
    input wire logic o_mode_strap_low_oe,
    input wire logic o_mode_strap_high_oe,
    input wire logic o_if_uart,
    input wire logic o_if_spi,
    input wire logic o_if_fifo,
    input wire logic o_mode_valid,
    input wire logic o_boot_mode,
    input wire logic o_fetch_from_rom,
    input wire logic [BIMS_BOOT_AW-1:0] o_rom_addr,
    input wire logic o_uart_load_en,
    input wire logic o_usb_load_en,
    input wire logic o_clk48_en,
    input wire logic o_uart_tick,
    input wire logic o_timer_irq
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Cycles since reset or since the last timer pulse
    logic [16:0] run_cyc_ff;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            run_cyc_ff <= 17'h00000;
        else if (o_timer_irq)
            run_cyc_ff <= 17'h00001;
        else
            run_cyc_ff <= run_cyc_ff + 17'h00001;
    end

    ////////////////////////////////////////////////////////////////////////
    one_iface_a: assert property (
        $onehot({o_if_uart, o_if_spi, o_if_fifo}) == o_mode_valid)
        else $error("interface select not one-hot");
    rst_quiet_a: assert property (
        disable iff (1'b0)
        !i_rst_n |=> !o_mode_valid && !o_mode_strap_low_oe)
        else $error("outputs active in reset");
    valid_delay_a: assert property (
        $rose(i_rst_n) |-> !o_mode_valid[*5] ##1 o_mode_valid)
        else $error("mode valid at wrong time");
    mode_frozen_a: assert property (
        o_mode_valid && $past(o_mode_valid)
        |-> $stable({o_if_uart, o_if_spi, o_if_fifo, o_boot_mode}))
        else $error("latched mode changed");
    low_oe_fifo_a: assert property (
        o_mode_strap_low_oe == (o_mode_valid && o_if_fifo))
        else $error("low strap enable wrong");
    high_undriven_a: assert property (!o_mode_strap_high_oe)
        else $error("high strap driven");
    rom_fetch_a: assert property (
        (o_fetch_from_rom == o_boot_mode)
        && (o_rom_addr == i_fetch_addr[8:0]))
        else $error("rom fetch wrong");
    uart_load_a: assert property (
        o_uart_load_en == (o_boot_mode && o_if_uart))
        else $error("uart load enable wrong");
    usb_load_a: assert property (
        o_usb_load_en |-> o_mode_valid && !i_flash_blank)
        else $error("usb load on blank part");
    clk48_rate_a: assert property (
        o_clk48_en |=> !o_clk48_en ##[1:2] o_clk48_en)
        else $error("48 MHz enable spacing wrong");
    tick_pulse_a: assert property (o_uart_tick |=> !o_uart_tick)
        else $error("uart tick too long");
    timer_period_a: assert property (
        o_timer_irq == (run_cyc_ff == 17'(BIMS_TICK_CYC)))
        else $error("timer pulse off period");
endmodule // bims_mode_select_sva
bind bims_mode_select bims_mode_select_sva u_sva (.*);

// ---- verif/tb.sv ----
// Self-checking bench for the mode select block
`timescale 1ns/100ps
module tb;
    import bims_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic pull_lo = 1'b1;
    logic pull_hi = 1'b1;
    logic boot_run = 1'b1;
    logic i_flash_blank = 1'b1;
    logic i_usb_upgrade_req = 1'b0;
    logic i_strap_low_out = 1'b0;
    logic [BIMS_PRESC_W-1:0] i_presc_divisor = 20'h00030;
    logic [BIMS_BOOT_SELECT_N_AW-1:0] i_fetch_addr = 16'h0000;
    logic [15:0] lfsr = 16'h0002;
    logic pin_lo, pin_hi, boot_n, lo_d, lo_oe, hi_d, hi_oe, if_u, if_s, if_f;
    logic valid, boot_m, rom_f, ld_u, ld_usb, c48, c24, tick, irq;
    logic [BIMS_BOOT_AW-1:0] rom_a;
    logic [2:0] exp;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n, m, dv, q;
    bims_host_model u_bims_host_model (.i_pull_low(pull_lo),
        .i_pull_high(pull_hi), .i_boot_run(boot_run), .i_dev_low(lo_d),
        .i_dev_low_oe(lo_oe), .i_dev_high(hi_d), .i_dev_high_oe(hi_oe),
        .o_pin_low(pin_lo), .o_pin_high(pin_hi), .o_boot_select_n(boot_n));
    bims_mode_select u_bims_mode_select (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_boot_select_n(boot_n),
        .i_mode_strap_low(pin_lo), .i_mode_strap_high(pin_hi),
        .i_flash_blank(i_flash_blank), .i_usb_upgrade_req(i_usb_upgrade_req),
        .i_strap_low_out(i_strap_low_out), .i_presc_divisor(i_presc_divisor),
        .i_fetch_addr(i_fetch_addr), .o_mode_strap_low(lo_d),
        .o_mode_strap_low_oe(lo_oe), .o_mode_strap_high(hi_d),
        .o_mode_strap_high_oe(hi_oe), .o_if_uart(if_u), .o_if_spi(if_s),
        .o_if_fifo(if_f), .o_mode_valid(valid), .o_boot_mode(boot_m),
        .o_fetch_from_rom(rom_f), .o_rom_addr(rom_a), .o_uart_load_en(ld_u),
        .o_usb_load_en(ld_usb), .o_clk48_en(c48), .o_clk24_en(c24),
        .o_uart_tick(tick), .o_timer_irq(irq));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            give_verdict();
        end
    end
    // Random source, expected decode, compares
    function automatic logic [15:0] lfsr_next(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [2:0] exp_if(logic h, logic l);
        return (h && !l) ? 3'h2 : ((!h && l) ? 3'h4 : 3'h1);
    endfunction
    task automatic chk_bit(string s, logic e, logic g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s exp %b got %b", s, e, g);
        end
    endtask
    task automatic chk_near(string s, int e, int g, int tol);
        num_checks++;
        if (g < e - tol || g > e + tol)
        begin
            errors++;
            $display("unexpected %s exp %0d got %0d", s, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick_n(int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask
    // Set pins, pulse reset four cycles, wait for the latched mode
    task automatic do_reset(logic h, logic l, logic b);
        int k;
        tick_n(1);
        i_rst_n = 1'b0;
        pull_hi = h;
        pull_lo = l;
        boot_run = b;
        tick_n(2);
        chk_bit("low_oe_rst", 1'b0, lo_oe);
        tick_n(2);
        i_rst_n = 1'b1;
        k = 0;
        while (valid !== 1'b1 && k < 20)
        begin
            tick_n(1);
            k++;
        end
        chk_bit("mode_valid", 1'b1, valid);
        // One edge leaves reset state, then the settle count
        chk_near("valid_delay", 1 + BIMS_SETTLE_CYC, k, 0);
    endtask
    task automatic wait_tick(output int g);
        g = 0;
        do
        begin
            tick_n(1);
            g++;
        end
        while (tick !== 1'b1 && g < 1000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        for (int k = 0; k < 8; k++)
        begin
            lfsr = lfsr_next(lfsr);
            i_fetch_addr = lfsr;
            do_reset(k[1], k[0], k[2]);
            exp = exp_if(pull_hi, pull_lo);
            chk_bit("if_set", 1'b1, {if_f, if_s, if_u} === exp);
            chk_bit("boot_mode", !boot_run, boot_m);
            chk_bit("rom_fetch", !boot_run, rom_f);
            chk_bit("rom_addr", 1'b1, rom_a === i_fetch_addr[8:0]);
            chk_bit("uart_load", !boot_run && exp[0], ld_u);
            // Move every pin after the latch
            i_strap_low_out = lfsr[3];
            pull_hi = !pull_hi;
            pull_lo = !pull_lo;
            boot_run = !boot_run;
            tick_n(4);
            chk_bit("if_hold", 1'b1, {if_f, if_s, if_u} === exp);
            chk_bit("boot_hold", boot_run, boot_m);
            chk_bit("low_oe", exp[2], lo_oe);
            chk_bit("low_pin", exp[2] ? i_strap_low_out : pull_lo, pin_lo);
            chk_bit("high_pin", pull_hi, pin_hi);
            chk_bit("high_data", 1'b0, hi_d);
        end
        i_flash_blank = 1'b0;
        i_usb_upgrade_req = 1'b1;
        tick_n(2);
        chk_bit("usb_load", 1'b1, ld_usb);
        i_flash_blank = 1'b1;
        tick_n(2);
        chk_bit("usb_blank", 1'b0, ld_usb);
        // Divisor below the clamp, the updater's rate, then random ones
        for (int k = 0; k < 4; k++)
        begin
            lfsr = lfsr_next(lfsr);
            dv = (k == 0) ? 10
               : ((k == 1) ? int'(BIMS_PRESC_RST)
               : 48 + lfsr[5:0]);
            i_presc_divisor = 20'(dv);
            repeat (3) wait_tick(n);
            chk_near("tick_gap", ((dv < 48) ? 48 : dv) * 100 / 48, n, 3);
        end
        n = 0;
        m = 0;
        q = 0;
        repeat (1000)
        begin
            tick_n(1);
            n += int'(c48 === 1'b1);
            m += int'(c24 === 1'b1);
            q += int'(irq === 1'b1);
        end
        chk_near("clk48_count", 480, n, 5);
        chk_near("clk24_count", 240, m, 5);
        // Far fewer cycles than one timer period since the last reset
        chk_near("timer_irq_count", 0, q, 0);
        give_verdict();
    end
endmodule // tb
